// ===== ioxc_regs.svh
// Purpose: offsets, field positions and reset values of the expander setup slice
// Assumes: byte-wide register port, pointer wraps to zero after the last register
// Notes: types live in ioxc_pkg, this header holds plain numbers only
// Operation
// (RULE1) set polarity bit inverts pin in port value
// (RULE2) enable bit arms pin for change interrupts
// (RULE3) host programs compare value and select first
// (RULE4) select one: mismatch against compare value interrupts
// (RULE5) select zero: change from previous level interrupts
// (RULE6) config bit 5 set freezes address pointer
// (RULE7) config bit 4 clear limits sda fall slew
// (RULE8) config bit 3 gates address pins, spi only
// (RULE9) config bit 2 set makes interrupt open-drain
// (RULE10) config bit 1 picks push-pull active level
// (RULE11) config bits 7, 6, 0 read zero
// (RULE12) only input pins can raise interrupts
// (RULE13) interrupt holds until capture or port read
// (RULE14) previous-value reference follows the new level
// (RULE15) unused bits dropped, all registers reset zero
`ifndef IOXC_REGS_SVH
`define IOXC_REGS_SVH

// register offsets
`define IOXC_ADDR_POL_INV 8'h01
`define IOXC_ADDR_CHG_EN 8'h02
`define IOXC_ADDR_CMP_VAL 8'h03
`define IOXC_ADDR_CMP_SEL 8'h04
`define IOXC_ADDR_CFG 8'h05
`define IOXC_ADDR_FLAG 8'h07
`define IOXC_ADDR_CAP 8'h08
`define IOXC_ADDR_PORT 8'h09
`define IOXC_ADDR_LAST 8'h0A

// configuration field positions
`define IOXC_CFG_SEQ_BIT 5
`define IOXC_CFG_SLEW_BIT 4
`define IOXC_CFG_HWADDR_BIT 3
`define IOXC_CFG_OD_BIT 2
`define IOXC_CFG_POL_BIT 1
`define IOXC_CFG_MASK 8'h3E

// reset value shared by every register
`define IOXC_RST_VAL 8'h00

`endif

// ===== ioxc_pkg.sv
// Purpose: shared types of the expander setup slice
// Assumes: offsets come from ioxc_regs.svh
// Notes: the request struct is what the serial engine hands over per byte
package ioxc_pkg;

   // one register-port request, all strobes one cycle wide
   typedef struct packed {
      logic ptr_load;       // load pointer from ptr_addr
      logic [7:0] ptr_addr; // new pointer value
      logic wr;             // write wdata at pointer
      logic rd;             // read at pointer
      logic [7:0] wdata;    // write byte
   } ioxc_req_t;

   // implemented configuration bits, high to low
   typedef struct packed {
      logic auto_increment_disable;
      logic sda_slew_disable;
      logic hw_address_pin_enable;
      logic irq_open_drain;
      logic irq_active_level;
   } ioxc_cfg_t;

   // interrupt state
   typedef enum logic [0:0] {
      IRQ_IDLE = 1'b0,
      IRQ_HELD = 1'b1
   } ioxc_irq_st_t;

endpackage

// ===== ioxc_chg_det.sv
// Purpose: per-pin interrupt-on-change mismatch detection
// Assumes: pin levels already synchronous to ref_clk
// Notes: output is combinational, the top registers the result
`timescale 1ns/100ps
module ioxc_chg_det #(
   parameter int WIDTH = 8
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // pin levels and setup
   input wire logic [WIDTH-1:0] pin_level,
   input wire logic [WIDTH-1:0] pin_is_input,
   input wire logic [WIDTH-1:0] chg_enable,
   input wire logic [WIDTH-1:0] cmp_value,
   input wire logic [WIDTH-1:0] cmp_select,
   // per-pin mismatch
   output logic [WIDTH-1:0] chg_cond
);
   // level seen one cycle ago
   logic [WIDTH-1:0] ref_ff;

   // (RULE14) reference tracks level
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         ref_ff <= '0;
      end else begin
         ref_ff <= pin_level;
      end
   end

   // one comparator per pin
   for (genvar i = 0; i < WIDTH; i++) begin : g_pin
      // (RULE4) (RULE5) select the basis
      wire logic diff = cmp_select[i] ? (pin_level[i] ^ cmp_value[i])
                                      : (pin_level[i] ^ ref_ff[i]);
      // (RULE2) (RULE12) enabled inputs only
      assign chg_cond[i] = chg_enable[i] & pin_is_input[i] & diff;
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   en_gate_a: assert property ((chg_cond & ~chg_enable) == '0) // RULE2
      else $error("change raised on a disabled pin");
   out_pins_a: assert property ((chg_cond & ~pin_is_input) == '0) // RULE12
      else $error("output pin raised a change");
   val_cmp_a: assert property ( // RULE4
      ((chg_cond ^ (pin_level ^ cmp_value)) & chg_enable & pin_is_input & cmp_select) == '0)
      else $error("compare-value mismatch not followed");
   prev_cmp_a: assert property (##1 ( // RULE5
      ((chg_cond ^ (pin_level ^ $past(pin_level))) & chg_enable & pin_is_input
       & ~cmp_select) == '0))
      else $error("previous-value change not followed");
endmodule // ioxc_chg_det

// ===== ioxc_irq_drv.sv
// Purpose: interrupt pin drive, open-drain or push-pull
// Assumes: irq_active is a registered level
// Notes: reset state matches reset config, push-pull active-low, idle high
`timescale 1ns/100ps
module ioxc_irq_drv (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // interrupt state and drive setup
   input wire logic irq_active,
   input wire logic open_drain,
   input wire logic active_high,
   // pin drive
   output logic irq_out,
   output logic irq_oe
);
   // drive registers
   logic out_ff, oe_ff;
   logic nxt_out, nxt_oe;

   // (RULE9) open-drain pulls low only
   assign nxt_oe = ~open_drain | irq_active;
   // (RULE10) push-pull level from polarity
   assign nxt_out = ~open_drain & ~(irq_active ^ active_high);

   // pin registers
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         out_ff <= 1'b1;
         oe_ff <= 1'b1;
      end else begin
         out_ff <= nxt_out;
         oe_ff <= nxt_oe;
      end
   end

   assign irq_out = out_ff;
   assign irq_oe = oe_ff;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   od_active_a: assert property (open_drain && irq_active |=> irq_oe && !irq_out) // RULE9
      else $error("open-drain active not pulled low");
   od_idle_a: assert property (open_drain && !irq_active |=> !irq_oe) // RULE9
      else $error("open-drain idle still driven");
   pp_level_a: assert property (!open_drain |=> // RULE10
      irq_oe && (irq_out == ($past(active_high) ~^ $past(irq_active))))
      else $error("push-pull level wrong");
endmodule // ioxc_irq_drv

// ===== ioxc_top.sv
// Purpose: setup registers and interrupt-on-change logic of an 8-pin expander
// Assumes: serial engine delivers one-cycle strobes in ioxc_req_t, pins synchronous
// Notes: direction comes from outside; registers not held here read as zero
`timescale 1ns/100ps
`include "ioxc_regs.svh"
module ioxc_top #(
   // one for the spi variant with switchable address pins
   parameter bit SPI_VARIANT = 1'b1
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // register port from the serial engine
   input wire ioxc_pkg::ioxc_req_t reg_req,
   output logic [7:0] reg_rdata,
   output logic [7:0] reg_ptr,
   // port pins and their direction, one means input
   input wire logic [7:0] pin_level,
   input wire logic [7:0] pin_direction,
   // interrupt pin
   output logic irq_out,
   output logic irq_oe,
   // pad controls for the serial engine
   output logic sda_slew_limit,
   output logic hw_address_active
);
   import ioxc_pkg::*;

   // setup registers
   logic [7:0] pol_inv_ff;
   logic [7:0] chg_en_ff;
   logic [7:0] cmp_val_ff;
   logic [7:0] cmp_sel_ff;
   ioxc_cfg_t cfg_ff;
   ioxc_cfg_t nxt_cfg;

   // register port state
   logic [7:0] ptr_ff;
   logic [7:0] nxt_ptr;
   logic [7:0] rdata_ff;

   // pad control registers
   logic slew_ff;
   logic hwaddr_ff;

   // interrupt state
   ioxc_irq_st_t irq_st_ff;
   ioxc_irq_st_t nxt_irq_st;
   logic [7:0] flag_ff;
   logic [7:0] nxt_flag;
   logic [7:0] cap_ff;
   logic [7:0] nxt_cap;

   // combinational helpers
   logic [7:0] chg_cond;     // per-pin mismatch
   logic [7:0] port_value;   // pins after polarity
   logic [7:0] rd_mux;       // read selection
   logic [7:0] cfg_rd;       // config as read back
   logic byte_ok;            // strobe not overridden by pointer load
   logic wr_ok;              // accepted write
   logic rd_ok;              // accepted read
   logic any_cond;           // some pin mismatched
   logic clr_rd;             // read that clears the interrupt
   logic ptr_step;           // pointer advances this cycle
   logic irq_active;         // interrupt asserted

   // a pointer load wins over a byte strobe in the same cycle
   assign byte_ok = ~reg_req.ptr_load;
   assign wr_ok = reg_req.wr & byte_ok;
   assign rd_ok = reg_req.rd & byte_ok;

   // (RULE1) polarity applied to port value
   assign port_value = pin_level ^ pol_inv_ff;

   // (RULE11) unimplemented bits read zero
   assign cfg_rd = {2'b00, cfg_ff, 1'b0};

   // read selection, unmapped and absent offsets give zero
   assign rd_mux = (ptr_ff == `IOXC_ADDR_POL_INV) ? pol_inv_ff :
                   (ptr_ff == `IOXC_ADDR_CHG_EN) ? chg_en_ff :
                   (ptr_ff == `IOXC_ADDR_CMP_VAL) ? cmp_val_ff :
                   (ptr_ff == `IOXC_ADDR_CMP_SEL) ? cmp_sel_ff :
                   (ptr_ff == `IOXC_ADDR_CFG) ? cfg_rd :
                   (ptr_ff == `IOXC_ADDR_FLAG) ? flag_ff :
                   (ptr_ff == `IOXC_ADDR_CAP) ? cap_ff :
                   (ptr_ff == `IOXC_ADDR_PORT) ? port_value : `IOXC_RST_VAL;

   // (RULE15) only implemented bits are kept
   assign nxt_cfg.auto_increment_disable = reg_req.wdata[`IOXC_CFG_SEQ_BIT];
   assign nxt_cfg.sda_slew_disable = reg_req.wdata[`IOXC_CFG_SLEW_BIT];
   assign nxt_cfg.hw_address_pin_enable = reg_req.wdata[`IOXC_CFG_HWADDR_BIT];
   assign nxt_cfg.irq_open_drain = reg_req.wdata[`IOXC_CFG_OD_BIT];
   assign nxt_cfg.irq_active_level = reg_req.wdata[`IOXC_CFG_POL_BIT];

   // (RULE6) pointer frozen when set
   assign ptr_step = (wr_ok | rd_ok) & ~cfg_ff.auto_increment_disable;

   // pointer wraps to zero after the last register
   assign nxt_ptr = reg_req.ptr_load ? reg_req.ptr_addr :
                    !ptr_step ? ptr_ff :
                    (ptr_ff >= `IOXC_ADDR_LAST) ? 8'h00 : 8'(ptr_ff + 8'h01);

   // (RULE13) capture or port read clears
   assign clr_rd = rd_ok & ((ptr_ff == `IOXC_ADDR_CAP) | (ptr_ff == `IOXC_ADDR_PORT));
   assign any_cond = |chg_cond;
   assign irq_active = (irq_st_ff == IRQ_HELD);

   // mismatch detection per pin
   ioxc_chg_det #(
      .WIDTH(8)
   ) u_det (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .pin_level(pin_level),
      .pin_is_input(pin_direction),
      .chg_enable(chg_en_ff),
      .cmp_value(cmp_val_ff),
      .cmp_select(cmp_sel_ff),
      .chg_cond(chg_cond)
   );

   // setup register writes
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         pol_inv_ff <= `IOXC_RST_VAL;
         chg_en_ff <= `IOXC_RST_VAL;
         cmp_val_ff <= `IOXC_RST_VAL;
         cmp_sel_ff <= `IOXC_RST_VAL;
         cfg_ff <= '0;
      end else if (wr_ok) begin
         // writes elsewhere, flag and capture included, are ignored
         if (ptr_ff == `IOXC_ADDR_POL_INV) pol_inv_ff <= reg_req.wdata;
         if (ptr_ff == `IOXC_ADDR_CHG_EN) chg_en_ff <= reg_req.wdata;
         if (ptr_ff == `IOXC_ADDR_CMP_VAL) cmp_val_ff <= reg_req.wdata;
         if (ptr_ff == `IOXC_ADDR_CMP_SEL) cmp_sel_ff <= reg_req.wdata;
         if (ptr_ff == `IOXC_ADDR_CFG) cfg_ff <= nxt_cfg;
      end
   end

   // pointer and read data
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         ptr_ff <= 8'h00;
         rdata_ff <= `IOXC_RST_VAL;
      end else begin
         ptr_ff <= nxt_ptr;
         if (rd_ok) rdata_ff <= rd_mux;
      end
   end

   // pad controls, registered so outputs come from flops
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         slew_ff <= 1'b1;
         hwaddr_ff <= ~SPI_VARIANT;
      end else begin
         // (RULE7) slew limit unless disabled
         slew_ff <= ~cfg_ff.sda_slew_disable;
         // (RULE8) bit matters on spi only
         hwaddr_ff <= ~SPI_VARIANT | cfg_ff.hw_address_pin_enable;
      end
   end

   // interrupt state machine; a new mismatch in the clearing cycle wins
   always_comb begin
      nxt_irq_st = irq_st_ff;
      nxt_flag = flag_ff;
      nxt_cap = cap_ff;
      case (irq_st_ff)
         IRQ_IDLE: begin
            // (RULE2) first enabled mismatch captures
            if (any_cond) begin
               nxt_irq_st = IRQ_HELD;
               nxt_flag = chg_cond;
               nxt_cap = port_value;
            end
         end
         IRQ_HELD: begin
            if (clr_rd && any_cond) begin
               // set wins over clear, recapture
               nxt_flag = chg_cond;
               nxt_cap = port_value;
            end else if (clr_rd) begin
               // capture value kept until the next interrupt
               nxt_irq_st = IRQ_IDLE;
               nxt_flag = 8'h00;
            end else begin
               // later mismatches show in flags only
               nxt_flag = flag_ff | chg_cond;
            end
         end
         default: begin
            nxt_irq_st = IRQ_IDLE;
         end
      endcase
   end

   // interrupt registers
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         irq_st_ff <= IRQ_IDLE;
         flag_ff <= `IOXC_RST_VAL;
         cap_ff <= `IOXC_RST_VAL;
      end else begin
         irq_st_ff <= nxt_irq_st;
         flag_ff <= nxt_flag;
         cap_ff <= nxt_cap;
      end
   end

   // interrupt pin drive
   ioxc_irq_drv u_drv (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .irq_active(irq_active),
      .open_drain(cfg_ff.irq_open_drain),
      .active_high(cfg_ff.irq_active_level),
      .irq_out(irq_out),
      .irq_oe(irq_oe)
   );

   // output wiring, all from flops
   assign reg_rdata = rdata_ff;
   assign reg_ptr = ptr_ff;
   assign sda_slew_limit = slew_ff;
   assign hw_address_active = hwaddr_ff;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   // steps of the interrupt life
   sequence seq_raise;
      irq_st_ff == IRQ_IDLE && any_cond;
   endsequence
   sequence seq_held_quiet;
      irq_st_ff == IRQ_HELD && !clr_rd;
   endsequence
   sequence seq_clear_quiet;
      irq_st_ff == IRQ_HELD && clr_rd && !any_cond;
   endsequence

   pol_read_a: assert property (rd_ok && ptr_ff == `IOXC_ADDR_PORT |=> // RULE1
      reg_rdata == ($past(pin_level) ^ $past(pol_inv_ff)))
      else $error("port read ignores polarity");
   irq_raise_a: assert property (seq_raise |=> irq_st_ff == IRQ_HELD // RULE2
      && cap_ff == $past(port_value) ##1 irq_oe)
      else $error("interrupt not raised and captured");
   ptr_hold_a: assert property ((wr_ok || rd_ok) && cfg_ff.auto_increment_disable // RULE6
      |=> ptr_ff == $past(ptr_ff))
      else $error("pointer moved while frozen");
   ptr_step_a: assert property ((wr_ok || rd_ok) && !cfg_ff.auto_increment_disable // RULE6
      && ptr_ff < `IOXC_ADDR_LAST |=> ptr_ff == $past(ptr_ff) + 8'h01)
      else $error("pointer failed to advance");
   slew_a: assert property (cfg_ff.sda_slew_disable [*2] |-> !sda_slew_limit) // RULE7
      else $error("slew limit not disabled");
   hwaddr_a: assert property (##1 hw_address_active == // RULE8
      (!SPI_VARIANT || $past(cfg_ff.hw_address_pin_enable)))
      else $error("address pin enable wrong");
   unimpl_zero_a: assert property (rd_ok && ptr_ff == `IOXC_ADDR_CFG |=> // RULE11
      (reg_rdata & ~`IOXC_CFG_MASK) == 8'h00)
      else $error("unimplemented config bits read nonzero");
   irq_hold_a: assert property (seq_held_quiet |=> irq_st_ff == IRQ_HELD // RULE13
      && cap_ff == $past(cap_ff))
      else $error("interrupt dropped without clearing read");
   irq_clear_a: assert property (seq_clear_quiet |=> irq_st_ff == IRQ_IDLE // RULE13
      && flag_ff == 8'h00)
      else $error("clearing read did not clear");
   cfg_reset_a: assert property (@(posedge ref_clk) disable iff (1'b0) // RULE15
      !rstn |=> cfg_ff == '0 && pol_inv_ff == 8'h00 && chg_en_ff == 8'h00
      && cmp_val_ff == 8'h00 && cmp_sel_ff == 8'h00)
      else $error("registers not cleared by reset");
endmodule // ioxc_top

// ===== ioxc_host_model.sv
// Purpose: host side of the register port, one byte request per call
// Assumes: strobes change at the falling edge, the design samples at the rising one
// Notes: released data fields show the inverted last value, never a held copy
`timescale 1ns/100ps
module ioxc_host_model (
   // clock
   input wire logic ref_clk,
   // register port
   output ioxc_pkg::ioxc_req_t req,
   input wire logic [7:0] rdata
);
   import ioxc_pkg::*;

   // idle request from time zero
   initial begin
      req = '0;
   end

   // one-cycle pointer load
   task automatic set_ptr(input logic [7:0] a);
      @(negedge ref_clk);
      req.ptr_load = 1'b1;
      req.ptr_addr = a;
      @(negedge ref_clk);
      req.ptr_load = 1'b0;
      req.ptr_addr = ~a;
   endtask

   // one-cycle byte write at the pointer
   task automatic wr_byte(input logic [7:0] d);
      @(negedge ref_clk);
      req.wr = 1'b1;
      req.wdata = d;
      @(negedge ref_clk);
      req.wr = 1'b0;
      req.wdata = ~d;
   endtask

   // one-cycle read, data settled by the next falling edge
   task automatic rd_byte(output logic [7:0] d);
      @(negedge ref_clk);
      req.rd = 1'b1;
      @(negedge ref_clk);
      req.rd = 1'b0;
      d = rdata;
   endtask

   // compare basis first
   // value and select are set before any pin is armed
   task automatic arm(input logic [7:0] en, input logic [7:0] cmp, input logic [7:0] sel);
      // disarm first, a half-written basis must not fire on old enables
      set_ptr(8'h02);
      wr_byte(8'h00);
      set_ptr(8'h03);
      wr_byte(cmp);
      wr_byte(sel);
      set_ptr(8'h02);
      wr_byte(en);
   endtask
endmodule // ioxc_host_model

// ===== testbench.sv
// Purpose: self-checking bench for the expander setup slice
// Assumes: host model drives the register port, bench drives the pins
// Notes: a second instance of the i2c variant checks its pin drive and pad flags
`timescale 1ns/100ps
module testbench;
   import ioxc_pkg::*;
   // clock, reset and pins
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] pin_level = 8'h00;
   logic [7:0] pin_direction = 8'hFF;
   // design outputs
   ioxc_req_t req;
   logic [7:0] rdata, ptr, rd_v;
   logic irq_out, irq_oe, slew, haddr, haddr_b;
   logic irq_b, oe_b, slew_b;
   // bench state, cfg_v mirrors the config byte written
   logic [7:0] cfg_v = 8'h00;
   int n_errors = 0;
   int n_tests = 0;
   int cycles = 0;

   // 125 MHz
   always #4 ref_clk = ~ref_clk;

   ioxc_host_model u_host (.ref_clk(ref_clk), .req(req), .rdata(rdata));

   ioxc_top u_dut (.ref_clk(ref_clk), .rstn(rstn), .reg_req(req),
      .reg_rdata(rdata), .reg_ptr(ptr), .pin_level(pin_level),
      .pin_direction(pin_direction), .irq_out(irq_out), .irq_oe(irq_oe),
      .sda_slew_limit(slew), .hw_address_active(haddr));

   // i2c variant, same traffic
   ioxc_top #(.SPI_VARIANT(1'b0)) u_dut_i2c (.ref_clk(ref_clk), .rstn(rstn), .reg_req(req),
      .reg_rdata(), .reg_ptr(), .pin_level(pin_level), .pin_direction(pin_direction),
      .irq_out(irq_b), .irq_oe(oe_b), .sda_slew_limit(slew_b), .hw_address_active(haddr_b));

   // compare and count
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // interrupt pin expected from mirrored config
   task automatic chk_irq(input logic act);
      logic [1:0] e;
      if (cfg_v[2]) e = act ? 2'b10 : 2'b00;
      else e = {1'b1, act ? cfg_v[1] : ~cfg_v[1]};
      chk({6'h00, irq_oe, irq_out}, {6'h00, e});
      chk({6'h00, oe_b, irq_b}, {6'h00, e});
   endtask

   task automatic rd_at(input logic [7:0] a, input logic [7:0] exp);
      u_host.set_ptr(a);
      u_host.rd_byte(rd_v);
      chk(rd_v, exp);
   endtask

   task automatic wr_at(input logic [7:0] a, input logic [7:0] d);
      u_host.set_ptr(a);
      u_host.wr_byte(d);
   endtask

   task automatic set_cfg(input logic [7:0] d);
      wr_at(8'h05, d);
      // pad and pin registers follow the config one edge later
      @(negedge ref_clk);
      cfg_v = d;
   endtask

   // pins move off the sampling edge, then the irq path settles
   task automatic set_pins(input logic [7:0] v);
      @(negedge ref_clk);
      pin_level = v;
      repeat (3) @(negedge ref_clk);
   endtask

   task automatic final_report();
      if (n_errors == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // hang guard, the run needs well under a thousand cycles
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 5000) begin
         n_errors++;
         final_report();
      end
   end

   initial begin
      repeat (20) @(negedge ref_clk);
      rstn = 1'b1;
      // reset state
      chk_irq(1'b0);
      chk({4'h0, slew_b, slew, haddr_b, haddr}, 8'h0E);
      for (int a = 1; a < 6; a++) rd_at(a[7:0], 8'h00);
      rd_at(8'h0A, 8'h00);
      chk(ptr, 8'h00);
      // sequential fill and read back
      u_host.set_ptr(8'h01);
      for (int a = 1; a < 5; a++) u_host.wr_byte({a[3:0], 4'h3});
      chk(ptr, 8'h05);
      u_host.set_ptr(8'h01);
      for (int a = 1; a < 5; a++) begin
         u_host.rd_byte(rd_v);
         chk(rd_v, {a[3:0], 4'h3});
      end
      // select 43 against value 33 leaves pins 0 and 1 mismatched
      chk_irq(1'b1);
      u_host.set_ptr(8'h01);
      for (int a = 1; a < 5; a++) u_host.wr_byte(8'h00);
      rd_at(8'h07, 8'h03);
      rd_at(8'h08, 8'h13);
      // every config bit set, unused ones must drop
      set_cfg(8'hFF);
      rd_at(8'h05, 8'h3E);
      chk(ptr, 8'h05);
      chk({4'h0, slew_b, slew, haddr_b, haddr}, 8'h03);
      chk_irq(1'b0);
      set_cfg(8'h00);
      chk({4'h0, slew_b, slew, haddr_b, haddr}, 8'h0E);
      // polarity inversion on the port value
      wr_at(8'h01, 8'h0F);
      set_pins(8'h5A);
      rd_at(8'h09, 8'h55);
      wr_at(8'h01, 8'h00);
      // compare-value mode on pin 0
      set_pins(8'h00);
      u_host.arm(8'h01, 8'h01, 8'h01);
      repeat (3) @(negedge ref_clk);
      chk_irq(1'b1);
      rd_at(8'h07, 8'h01);
      wr_at(8'h08, 8'h00);
      wr_at(8'h09, 8'h00);
      chk_irq(1'b1);
      rd_at(8'h08, 8'h00);
      repeat (2) @(negedge ref_clk);
      chk_irq(1'b1);
      set_pins(8'h01);
      rd_at(8'h09, 8'h01);
      repeat (2) @(negedge ref_clk);
      chk_irq(1'b0);
      // previous-value mode, pin 3 an output, pin 2 not armed
      @(negedge ref_clk);
      pin_direction = 8'hF7;
      u_host.arm(8'h0A, 8'h00, 8'h00);
      set_pins(8'h0D);
      chk_irq(1'b0);
      set_pins(8'h0F);
      chk_irq(1'b1);
      rd_at(8'h07, 8'h02);
      rd_at(8'h09, 8'h0F);
      repeat (4) @(negedge ref_clk);
      chk_irq(1'b0);
      set_pins(8'h0D);
      chk_irq(1'b1);
      rd_at(8'h08, 8'h0D);
      repeat (2) @(negedge ref_clk);
      chk_irq(1'b0);
      // drive modes while held
      set_cfg(8'h02);
      set_pins(8'h0F);
      chk_irq(1'b1);
      set_cfg(8'h06);
      repeat (2) @(negedge ref_clk);
      chk_irq(1'b1);
      rd_at(8'h09, 8'h0F);
      repeat (2) @(negedge ref_clk);
      chk_irq(1'b0);
      final_report();
   end
endmodule // testbench
